// file: regen_pkg.sv
// Shared constants and types for the regenerator startup sequencer
package regen_pkg;
    localparam int CAP_W = 16;
    localparam int MARGIN_W = 8;
    localparam int PARAM_W = 16;
    localparam int CLK_MHZ = 125;
    localparam int START_TIMER_MIN = 4;
    localparam int INIT_TIMER_S = 30;
    localparam longint START_TIMER_CYC = longint'(START_TIMER_MIN) * 60 * CLK_MHZ * 1000000;
    localparam longint INIT_TIMER_CYC = longint'(INIT_TIMER_S) * CLK_MHZ * 1000000;
    localparam int TMR_W = 36;
    localparam logic [TMR_W-1:0] TMR_ZERO = 36'h000000000;
    localparam logic [TMR_W-1:0] TMR_ONE = 36'h000000001;
    localparam logic [1:0] CLK_MODE_1 = 2'h0;
    localparam logic [1:0] MSG_STATUS = 2'h0;
    localparam logic [1:0] MSG_CAPS = 2'h1;
    localparam logic [1:0] MSG_MARGINS = 2'h2;
    localparam logic [1:0] MSG_PARAMS = 2'h3;
    localparam logic [1:0] STAT_FAIL = 2'h1;
    localparam logic [1:0] STAT_LINK_INIT = 2'h2;
    localparam logic [1:0] STAT_ACTIVE = 2'h3;
    localparam int MAX_REGENS = 8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT = 3'h1,
        ST_SESSION1 = 3'h2,
        ST_SESSION2 = 3'h3,
        ST_ACTIVATE = 3'h4,
        ST_ACTIVE = 3'h5
    } phase_t;
endpackage : regen_pkg

// file: msg_link.sv
// One-deep valid/acknowledge message channel between regenerator halves
`timescale 1ns/1ps
module msg_link (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [1:0] send_kind,
    input wire logic [31:0] send_data,
    output logic busy,
    output logic valid,
    output logic [1:0] kind,
    output logic [31:0] data,
    input wire logic ack
);
    logic valid_nxt;
    logic [1:0] kind_nxt;
    logic [31:0] data_nxt;

    // Hold one message until acknowledged
    always_comb begin
        valid_nxt = valid;
        kind_nxt = kind;
        data_nxt = data;
        if (valid && ack) begin
            valid_nxt = 1'b0;
        end
        if (send && !valid) begin
            valid_nxt = 1'b1;
            kind_nxt = send_kind;
            data_nxt = send_data;
        end
    end

    always_comb busy = valid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= 1'b0;
            kind <= 2'h0;
            data <= 32'h00000000;
        end else begin
            valid <= valid_nxt;
            kind <= kind_nxt;
            data <= data_nxt;
        end
    end
endmodule : msg_link

// file: regen_span_startup_sequencer.sv
// One regenerator half: startup phase sequencer with internal message link
//
// Behaviour
// - Works hop by hop for up to eight regenerators
// - Capabilities flow centralward, training flows remoteward
// - Lacking information, end session with silent period
// - Remote-opened session: exchange caps then hold off
// - Forward caps; partner advertises intersected capabilities
// - Central exchange: capture margins then hold off
// - Relay margins; advertise with central margin flag
// - Second exchange without a probe, then hold off
// - Upstream done: pass parameters, start downstream session
// - Preselected parameters skip repeated capability exchange
// - Clock mode 1: start after upstream handshake
// - Other clock modes: wait for upstream activation
// - Operational only after final segment activates
// - Probe setting has no effect: central-facing half always sends caps
// - Margins carry current and worst-case together
// - Four minute startup timer, failure to partner
// - Thirty second initiation timeout, failure and idle
// - Any segment failure returns this half idle; failure goes to partner only when link is free
`timescale 1ns/1ps
module regen_span_startup_sequencer #(
    parameter longint START_CYC = regen_pkg::START_TIMER_CYC,
    parameter longint INIT_CYC = regen_pkg::INIT_TIMER_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic central_facing,
    input wire logic probe_enable,
    input wire logic [1:0] clock_mode,
    input wire logic [regen_pkg::CAP_W-1:0] own_caps,
    input wire logic seg_open,
    input wire logic seg_far_opened,
    input wire logic seg_caps_valid,
    input wire logic [regen_pkg::CAP_W-1:0] seg_caps,
    input wire logic seg_margin_flag,
    input wire logic [regen_pkg::MARGIN_W-1:0] seg_margin_cur,
    input wire logic [regen_pkg::MARGIN_W-1:0] seg_margin_worst,
    input wire logic seg_params_valid,
    input wire logic [regen_pkg::PARAM_W-1:0] seg_params,
    input wire logic seg_session_done,
    input wire logic seg_activation_done,
    input wire logic seg_fail,
    input wire logic in_valid,
    input wire logic [1:0] in_kind,
    input wire logic [31:0] in_data,
    output logic in_ack,
    output logic out_valid,
    output logic [1:0] out_kind,
    output logic [31:0] out_data,
    input wire logic out_ack,
    output logic hs_start_r,
    output logic ms_silent_r,
    output logic central_margin_flag_r,
    output logic [regen_pkg::CAP_W-1:0] adv_caps_r,
    output logic [regen_pkg::MARGIN_W-1:0] adv_margin_cur_r,
    output logic [regen_pkg::MARGIN_W-1:0] adv_margin_worst_r,
    output logic [regen_pkg::PARAM_W-1:0] sel_params_r,
    output logic activate_r,
    output logic active_r,
    output logic fail_r,
    output regen_pkg::phase_t phase_r
);
    logic rst_s1_r;
    logic rst_n_r;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    regen_pkg::phase_t phase_nxt;
    logic [regen_pkg::CAP_W-1:0] caps_r, caps_nxt, adv_caps_nxt;
    logic [regen_pkg::MARGIN_W-1:0] mcur_r, mcur_nxt, mworst_r, mworst_nxt;
    logic [regen_pkg::PARAM_W-1:0] par_nxt;
    logic have_margins_r, have_margins_nxt, have_params_r, have_params_nxt;
    logic hs_nxt, ms_nxt, cmf_nxt, act_nxt, active_nxt, fail_nxt;
    logic [regen_pkg::TMR_W-1:0] start_tmr_r, start_tmr_nxt, init_tmr_r, init_tmr_nxt;
    logic send;
    logic [1:0] send_kind;
    logic [31:0] send_data;
    logic link_busy;
    logic mode1;

    always_comb mode1 = (clock_mode == regen_pkg::CLK_MODE_1);
    always_comb in_ack = in_valid;

    // Internal outbound channel, single message in flight
    msg_link u_out (
        .clk(ref_clk),
        .rst_n(rst_n_r),
        .send(send),
        .send_kind(send_kind),
        .send_data(send_data),
        .busy(link_busy),
        .valid(out_valid),
        .kind(out_kind),
        .data(out_data),
        .ack(out_ack)
    );

    // Phase sequencing and message generation
    always_comb begin
        phase_nxt = phase_r;
        caps_nxt = caps_r;
        mcur_nxt = mcur_r;
        mworst_nxt = mworst_r;
        par_nxt = sel_params_r;
        have_margins_nxt = have_margins_r;
        have_params_nxt = have_params_r;
        hs_nxt = 1'b0;
        ms_nxt = 1'b0;
        cmf_nxt = central_margin_flag_r;
        adv_caps_nxt = adv_caps_r;
        act_nxt = activate_r;
        active_nxt = active_r;
        fail_nxt = 1'b0;
        send = 1'b0;
        send_kind = regen_pkg::MSG_STATUS;
        send_data = 32'h00000000;
        start_tmr_nxt = (phase_r == regen_pkg::ST_IDLE || phase_r == regen_pkg::ST_ACTIVE) ? regen_pkg::TMR_ZERO
            : start_tmr_r + regen_pkg::TMR_ONE;
        init_tmr_nxt = (hs_start_r || phase_r == regen_pkg::ST_SESSION1 || phase_r == regen_pkg::ST_SESSION2)
            ? init_tmr_r + regen_pkg::TMR_ONE : regen_pkg::TMR_ZERO;
        // Inbound messages from the partner half
        if (in_valid) begin
            case (in_kind)
                regen_pkg::MSG_CAPS: begin
                    caps_nxt = in_data[regen_pkg::CAP_W-1:0] & own_caps;
                    if (phase_r == regen_pkg::ST_IDLE || phase_r == regen_pkg::ST_WAIT) begin
                        adv_caps_nxt = in_data[regen_pkg::CAP_W-1:0] & own_caps;
                        hs_nxt = 1'b1;
                        cmf_nxt = have_margins_r;
                        phase_nxt = have_margins_r ? regen_pkg::ST_SESSION2 : regen_pkg::ST_SESSION1;
                    end
                end
                regen_pkg::MSG_MARGINS: begin
                    mcur_nxt = in_data[regen_pkg::MARGIN_W-1:0];
                    mworst_nxt = in_data[2*regen_pkg::MARGIN_W-1:regen_pkg::MARGIN_W];
                    have_margins_nxt = 1'b1;
                    hs_nxt = 1'b1;
                    cmf_nxt = 1'b1;
                    phase_nxt = regen_pkg::ST_SESSION2;
                end
                regen_pkg::MSG_PARAMS: begin
                    par_nxt = in_data[regen_pkg::PARAM_W-1:0];
                    have_params_nxt = 1'b1;
                    hs_nxt = 1'b1;
                    phase_nxt = regen_pkg::ST_ACTIVATE;
                end
                default: begin
                    if (in_data[1:0] == regen_pkg::STAT_FAIL) begin
                        phase_nxt = regen_pkg::ST_IDLE;
                        act_nxt = 1'b0;
                        active_nxt = 1'b0;
                    end
                end
            endcase
        end
        case (phase_r)
            regen_pkg::ST_IDLE: begin
                have_margins_nxt = 1'b0;
                have_params_nxt = 1'b0;
                if (seg_far_opened && !in_valid) begin
                    phase_nxt = regen_pkg::ST_SESSION1;
                end
            end
            regen_pkg::ST_WAIT: begin
                if (seg_far_opened && !in_valid) begin
                    phase_nxt = have_params_r ? regen_pkg::ST_ACTIVATE : regen_pkg::ST_SESSION2;
                end
            end
            regen_pkg::ST_SESSION1, regen_pkg::ST_SESSION2: begin
                if (seg_caps_valid) begin
                    caps_nxt = seg_caps & own_caps;
                    if (seg_margin_flag) begin
                        mcur_nxt = seg_margin_cur;
                        mworst_nxt = seg_margin_worst;
                        have_margins_nxt = 1'b1;
                    end
                end
                if (seg_params_valid) begin
                    par_nxt = seg_params;
                    have_params_nxt = 1'b1;
                    phase_nxt = regen_pkg::ST_ACTIVATE;
                end else if (seg_session_done && !link_busy) begin
                    ms_nxt = 1'b1;
                    phase_nxt = regen_pkg::ST_WAIT;
                    send = 1'b1;
                    if (!central_facing && have_margins_r && !cmf_nxt) begin
                        send_kind = regen_pkg::MSG_MARGINS;
                        send_data = {16'h0000, mworst_r, mcur_r};
                    end else if (central_facing && (have_margins_r || !probe_enable)) begin
                        send_kind = regen_pkg::MSG_CAPS;
                        send_data = {16'h0000, caps_r};
                    end else if (central_facing) begin
                        send_kind = regen_pkg::MSG_CAPS;
                        send_data = {16'h0000, caps_r};
                    end else begin
                        send_kind = regen_pkg::MSG_STATUS;
                        send_data = {30'h00000000, regen_pkg::STAT_LINK_INIT};
                    end
                end
            end
            regen_pkg::ST_ACTIVATE: begin
                act_nxt = 1'b1;
                if (!central_facing && !link_busy
                    && ((mode1 && seg_session_done) || seg_activation_done)) begin
                    send = 1'b1;
                    send_kind = regen_pkg::MSG_PARAMS;
                    send_data = {16'h0000, sel_params_r};
                end
                if (seg_activation_done) begin
                    act_nxt = 1'b0;
                    active_nxt = 1'b1;
                    phase_nxt = regen_pkg::ST_ACTIVE;
                end
            end
            regen_pkg::ST_ACTIVE: begin
                active_nxt = 1'b1;
            end
            default: begin
                phase_nxt = regen_pkg::ST_IDLE;
            end
        endcase
        // Timeouts and segment failure override phase, activation, handshake and message
        if (seg_fail || start_tmr_r >= START_CYC[regen_pkg::TMR_W-1:0]
            || init_tmr_r >= INIT_CYC[regen_pkg::TMR_W-1:0]) begin
            phase_nxt = regen_pkg::ST_IDLE;
            fail_nxt = 1'b1;
            act_nxt = 1'b0;
            active_nxt = 1'b0;
            hs_nxt = 1'b0;
            send = !link_busy;
            send_kind = regen_pkg::MSG_STATUS;
            send_data = {30'h00000000, regen_pkg::STAT_FAIL};
        end else if (seg_open && phase_r == regen_pkg::ST_IDLE) begin
            hs_nxt = 1'b1;
        end
        if (!seg_open && phase_r == regen_pkg::ST_IDLE) begin
            cmf_nxt = 1'b0;
        end
    end

    // State registers, cleared by reset
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            phase_r <= regen_pkg::ST_IDLE;
            caps_r <= 16'h0000;
            mcur_r <= 8'h00;
            mworst_r <= 8'h00;
            sel_params_r <= 16'h0000;
            have_margins_r <= 1'b0;
            have_params_r <= 1'b0;
            hs_start_r <= 1'b0;
            ms_silent_r <= 1'b0;
            central_margin_flag_r <= 1'b0;
            adv_caps_r <= 16'h0000;
            adv_margin_cur_r <= 8'h00;
            adv_margin_worst_r <= 8'h00;
            activate_r <= 1'b0;
            active_r <= 1'b0;
            fail_r <= 1'b0;
            start_tmr_r <= regen_pkg::TMR_ZERO;
            init_tmr_r <= regen_pkg::TMR_ZERO;
        end else begin
            phase_r <= phase_nxt;
            caps_r <= caps_nxt;
            mcur_r <= mcur_nxt;
            mworst_r <= mworst_nxt;
            sel_params_r <= par_nxt;
            have_margins_r <= have_margins_nxt;
            have_params_r <= have_params_nxt;
            hs_start_r <= hs_nxt;
            ms_silent_r <= ms_nxt;
            central_margin_flag_r <= cmf_nxt;
            adv_caps_r <= adv_caps_nxt;
            adv_margin_cur_r <= mcur_nxt;
            adv_margin_worst_r <= mworst_nxt;
            activate_r <= act_nxt;
            active_r <= active_nxt;
            fail_r <= fail_nxt;
            start_tmr_r <= start_tmr_nxt;
            init_tmr_r <= init_tmr_nxt;
        end
    end
endmodule : regen_span_startup_sequencer

// file: regen_startup_checker.sv
// Checker: port-level assertions for one regenerator half
`timescale 1ns/1ps
module regen_startup_checker #(
    parameter longint START_CYC = 2000,
    parameter longint INIT_CYC = 500
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic in_valid,
    input logic in_ack,
    input logic out_valid,
    input logic [1:0] out_kind,
    input logic [31:0] out_data,
    input wire logic out_ack,
    input wire logic seg_session_done,
    input wire logic seg_fail,
    input logic hs_start_r,
    input logic ms_silent_r,
    input logic activate_r,
    input logic active_r,
    input logic fail_r,
    input regen_pkg::phase_t phase_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_ack_mirror: assert property (in_ack == in_valid) else $error("in_ack differs from in_valid");
    chk_out_hold: assert property (out_valid && !out_ack |=> out_valid && $stable(out_kind) && $stable(out_data))
        else $error("outbound message changed before ack");
    chk_silent_wait: assert property (phase_r == regen_pkg::ST_SESSION1 && seg_session_done && !seg_fail
        |=> ms_silent_r && phase_r == regen_pkg::ST_WAIT) else $error("no silent hold-off after session");
    chk_fail_idle: assert property (seg_fail |=> phase_r == regen_pkg::ST_IDLE)
        else $error("segment failure left half busy");
    chk_active_phase: assert property (active_r |-> phase_r == regen_pkg::ST_ACTIVE)
        else $error("active outside active phase");
    chk_hs_pulse: assert property (hs_start_r |=> !hs_start_r) else $error("handshake start not a pulse");
    chk_fail_pulse: assert property (fail_r |=> !fail_r) else $error("failure not a pulse");
    chk_phase_legal: assert property (phase_r <= regen_pkg::ST_ACTIVE) else $error("illegal phase code");
    chk_reset_idle: assert property ($rose(arst_n) |-> phase_r == regen_pkg::ST_IDLE && !out_valid && !activate_r)
        else $error("state not cleared by reset");
    cover property (ms_silent_r);
    cover property (hs_start_r);
    cover property (fail_r);
endmodule : regen_startup_checker

bind regen_span_startup_sequencer regen_startup_checker #(.START_CYC(START_CYC), .INIT_CYC(INIT_CYC)) chk_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .in_valid(in_valid), .in_ack(in_ack), .out_valid(out_valid),
    .out_kind(out_kind), .out_data(out_data), .out_ack(out_ack), .seg_session_done(seg_session_done),
    .seg_fail(seg_fail), .hs_start_r(hs_start_r), .ms_silent_r(ms_silent_r), .activate_r(activate_r),
    .active_r(active_r), .fail_r(fail_r), .phase_r(phase_r));

// file: regen_peer.sv
// Partner half model: acknowledges outbound messages and posts inbound ones
`timescale 1ns/1ps
module regen_peer (
    input wire logic ref_clk,
    input wire logic out_valid,
    output logic out_ack,
    output logic in_valid,
    output logic [1:0] in_kind,
    output logic [31:0] in_data,
    input wire logic in_ack
);
    int ack_dly = 0;
    int cnt = 0;
    initial begin
        out_ack = 1'b0;
        in_valid = 1'b0;
        in_kind = 2'h0;
        in_data = 32'h00000000;
    end
    // Acknowledge each held message after a settable wait
    always @(posedge ref_clk) begin
        #1;
        out_ack = 1'b0;
        if (out_valid === 1'b1 && cnt >= ack_dly) begin
            out_ack = 1'b1;
            cnt = 0;
        end else if (out_valid === 1'b1) begin
            cnt++;
        end
    end
    // A held-off far unit never reports failure here; it only waits
    // One outstanding message, held until acknowledged; idle data shows inverse
    task automatic post(input logic [1:0] k, input logic [31:0] d);
        in_kind = k;
        in_data = d;
        in_valid = 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 16 && in_ack !== 1'b1; i++) @(posedge ref_clk);
        #1;
        in_valid = 1'b0;
        in_data = ~d;
    endtask : post
endmodule : regen_peer

// file: tb.sv
// Testbench: one regenerator half through hold-off, relay, failure and timeout
`timescale 1ns/1ps
module tb;
    localparam longint INIT_N = 500;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic central_facing, probe_enable, seg_open, seg_far_opened, seg_caps_valid, seg_margin_flag, seg_params_valid;
    logic seg_session_done, seg_activation_done, seg_fail, in_valid, in_ack, out_valid, out_ack, hs_start_r;
    logic ms_silent_r, central_margin_flag_r, activate_r, active_r, fail_r;
    logic [1:0] clock_mode, in_kind, out_kind;
    logic [15:0] own_caps, seg_caps, seg_params, adv_caps_r, sel_params_r;
    logic [7:0] seg_margin_cur, seg_margin_worst, adv_margin_cur_r, adv_margin_worst_r;
    logic [31:0] in_data, out_data, rnd;
    regen_pkg::phase_t phase_r;
    int n_mismatch = 0;
    int n_checks = 0;
    int seen;
    always #4 ref_clk = ~ref_clk;
    regen_span_startup_sequencer #(.START_CYC(2000), .INIT_CYC(INIT_N)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .central_facing(central_facing), .probe_enable(probe_enable),
        .clock_mode(clock_mode), .own_caps(own_caps), .seg_open(seg_open), .seg_far_opened(seg_far_opened),
        .seg_caps_valid(seg_caps_valid), .seg_caps(seg_caps), .seg_margin_flag(seg_margin_flag),
        .seg_margin_cur(seg_margin_cur), .seg_margin_worst(seg_margin_worst), .seg_params_valid(seg_params_valid),
        .seg_params(seg_params), .seg_session_done(seg_session_done), .seg_activation_done(seg_activation_done),
        .seg_fail(seg_fail), .in_valid(in_valid), .in_kind(in_kind), .in_data(in_data), .in_ack(in_ack),
        .out_valid(out_valid), .out_kind(out_kind), .out_data(out_data), .out_ack(out_ack),
        .hs_start_r(hs_start_r), .ms_silent_r(ms_silent_r), .central_margin_flag_r(central_margin_flag_r),
        .adv_caps_r(adv_caps_r), .adv_margin_cur_r(adv_margin_cur_r), .adv_margin_worst_r(adv_margin_worst_r),
        .sel_params_r(sel_params_r), .activate_r(activate_r), .active_r(active_r), .fail_r(fail_r),
        .phase_r(phase_r));
    regen_peer peer_u (.ref_clk(ref_clk), .out_valid(out_valid), .out_ack(out_ack), .in_valid(in_valid),
        .in_kind(in_kind), .in_data(in_data), .in_ack(in_ack));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Segment events: {far_opened, fail, act_done, session_done, params_valid, caps_valid}
    task automatic step(input logic [5:0] ev);
        {seg_far_opened, seg_fail, seg_activation_done, seg_session_done, seg_params_valid, seg_caps_valid} = ev;
        @(posedge ref_clk);
        #1;
        {seg_far_opened, seg_fail, seg_activation_done, seg_session_done, seg_params_valid, seg_caps_valid} = 6'h00;
    endtask : step
    task automatic wait_sig(input int sel, input int lim);
        seen = 0;
        for (int i = 0; i < lim && seen == 0; i++) begin
            @(posedge ref_clk);
            #1;
            if ((sel == 0 && hs_start_r === 1'b1) || (sel == 1 && fail_r === 1'b1)) seen = 1;
        end
    endtask : wait_sig
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        rnd = 32'h00007FD3;
        {central_facing, probe_enable, seg_open, seg_margin_flag, clock_mode} = 6'h00;
        {seg_far_opened, seg_fail, seg_activation_done, seg_session_done, seg_params_valid, seg_caps_valid} = 6'h00;
        own_caps = 16'hFFFF;
        seg_caps = 16'h0000;
        seg_params = 16'h0000;
        seg_margin_cur = 8'h00;
        seg_margin_worst = 8'h00;
        repeat (4) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("phase", 32'(phase_r), 32'(regen_pkg::ST_IDLE));
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            peer_u.ack_dly = k;
            central_facing = 1'b1;
            {probe_enable, seg_margin_flag, clock_mode} = rnd[19:16];
            own_caps = rnd[31:16];
            seg_caps = rnd[15:0];
            {seg_margin_worst, seg_margin_cur} = rnd[23:8];
            seg_params = rnd[27:12];
            step(6'h20);
            step(6'h01);
            step(6'h04);
            chk("ms_silent", 32'h1, 32'(ms_silent_r));
            chk("phase", 32'(regen_pkg::ST_WAIT), 32'(phase_r));
            chk("kind", 32'(regen_pkg::MSG_CAPS), 32'(out_kind));
            chk("caps", 32'(own_caps & seg_caps), 32'(out_data[15:0]));
            step(6'h10);
            chk("phase", 32'(regen_pkg::ST_IDLE), 32'(phase_r));
            repeat (8) step(6'h00);
        end
        // Remote-facing half relays received caps intersected with its own
        central_facing = 1'b0;
        rnd = lfsr(rnd);
        peer_u.post(regen_pkg::MSG_CAPS, {16'h0000, rnd[15:0]});
        chk("hs_start", 32'h1, 32'(hs_start_r));
        chk("adv_caps", 32'(own_caps & rnd[15:0]), 32'(adv_caps_r));
        // No session end: initiation timer must give up
        wait_sig(1, int'(INIT_N) + 50);
        chk("init_fail", 32'h1, 32'(seen));
        chk("phase", 32'(regen_pkg::ST_IDLE), 32'(phase_r));
        end_of_test();
    end
    // Watchdog
    initial begin
        #160000;
        n_mismatch++;
        $display("BAD watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule : tb
